// file: src/pspc_pkg.sv
// Purpose: Shared constants, types and helpers of the SRAM pin control
// Assumes: One clock, synchronous active-low reset
// Notes:   Lane A is data bits 7:0 with parity bit 0, lane B the rest
package pspc_pkg;

   // ***************************************************************
   // Sizes and reset values
   // ***************************************************************
   localparam int         ADDR_W     = 18;
   localparam int         DATA_W     = 16;
   localparam int         LANES      = 2;
   localparam int         BYTE_W     = 8;
   localparam int         LANE_W     = BYTE_W + 1;
   localparam int         DEPTH      = 1 << ADDR_W;
   localparam logic [1:0] BURST_RST  = 2'h0;
   localparam logic [1:0] BURST_STEP = 2'h1;
   localparam logic [1:0] STRAP_CAP  = 2'h2;
   localparam logic [1:0] STRAP_DONE = 2'h3;
   localparam logic       OE_N_RST   = 1'b1;
   localparam logic       SLEEP_RST  = 1'b0;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      PSPC_OP_IDLE  = 3'b001,
      PSPC_OP_READ  = 3'b010,
      PSPC_OP_WRITE = 3'b100
   } pspc_op_e;

   // Synchronous command pins, all sampled on the rising edge
   typedef struct packed {
      logic              chip_select_first_n;
      logic              chip_select_second_high;
      logic              chip_select_third_n;
      logic              write_enable_n;
      logic              adv_load;
      logic [LANES-1:0]  byte_write_select_n;
      logic [ADDR_W-1:0] address;
   } pspc_cmd_s;

   typedef struct packed {
      logic [1:0] base;
      logic [1:0] count;
   } pspc_burst_s;

   // Low address bits for a burst step, interleaved or linear
   function automatic logic [1:0] pspc_burst_lo(
      input logic [1:0] base,
      input logic [1:0] cnt,
      input logic       interleave);
      return interleave ? (base ^ cnt) : 2'(base + cnt);
   endfunction

endpackage

// file: src/pspc_burst.sv
// Purpose: Two-bit burst counter for the SRAM pin control
// Assumes: step is already qualified by clock qualifier and sleep
// Notes:   lo_next is the low address of the next burst beat
`timescale 1ns/1ps
module pspc_burst (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   input  wire logic       step,
   input  wire logic       load,
   input  wire logic [1:0] base_in,
   input  wire logic       interleave,
   output logic      [1:0] lo_next
);
   import pspc_pkg::*;

   pspc_burst_s st_q;
   pspc_burst_s st_d;

   // Load restarts the count, advance wraps after four beats
   always_comb begin
      st_d = st_q;
      if (step && load) begin
         st_d.base  = base_in;
         st_d.count = BURST_RST;
      end else if (step) begin
         st_d.count = 2'(st_q.count + BURST_STEP);
      end
      if (!rstn) begin
         st_d.base  = BURST_RST;
         st_d.count = BURST_RST;
      end
   end

   // Frozen while the clock enable is low
   always_ff @(posedge clk) begin
      if (clk_en || !rstn) begin
         st_q <= st_d;
      end
   end

   assign lo_next = pspc_burst_lo(st_q.base,
                                  2'(st_q.count + BURST_STEP),
                                  interleave);

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_burst_xor_order: assert property (
      @(posedge clk) disable iff (!rstn)
      (clk_en && step && load && interleave) ##1 interleave
      |-> lo_next == ($past(base_in) ^ BURST_STEP))
      else $error("interleaved burst beat not formed by xor");

endmodule

// file: src/pspc_ctrl.sv
// Purpose: Control pins, direction and pipeline of a burst SRAM
// Assumes: Controller drives command and write data on clk fall
// Notes:   Output enable and sleep are synchronised before use
`timescale 1ns/1ps
module pspc_ctrl (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       clk_en,
   input  wire pspc_pkg::pspc_cmd_s        cmd,
   input  wire logic                       clock_qualify_n,
   input  wire logic                       output_enable_n,
   input  wire logic                       sleep_request,
   input  wire logic                       burst_mode_strap,
   input  wire logic [pspc_pkg::DATA_W-1:0] dq_in,
   input  wire logic [pspc_pkg::LANES-1:0]  parity_lines_in,
   output logic      [pspc_pkg::DATA_W-1:0] dq_out,
   output logic                            dq_oe,
   output logic      [pspc_pkg::LANES-1:0]  parity_lines_out,
   output logic                            parity_lines_oe
);
   import pspc_pkg::*;

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic              oe_s1;
      logic              oe_s2;
      logic              zz_s1;
      logic              zz_s2;
      logic              md_s1;
      logic              md_s2;
      logic [1:0]        strap_cnt;
      logic              interleave;
      logic              asleep;
      pspc_op_e          st1_op;
      logic [ADDR_W-1:0] st1_addr;
      logic [LANES-1:0]  st1_bw;
      pspc_op_e          st2_op;
      logic [ADDR_W-1:0] st2_addr;
      logic [LANES-1:0]  st2_bw;
      logic [DATA_W-1:0] dq_out;
      logic [LANES-1:0]  par_out;
      logic              oe;
   } pspc_state_s;

   pspc_state_s st_q;
   pspc_state_s st_d;

   logic [LANE_W-1:0] mem_a [0:DEPTH-1];
   logic [LANE_W-1:0] mem_b [0:DEPTH-1];
   logic [LANE_W-1:0] rd_a;
   logic [LANE_W-1:0] rd_b;
   logic              step;
   logic              sel;
   logic [1:0]        lo_next;

   // ***************************************************************
   // Qualified edge and selection decode
   // ***************************************************************
   // Raised qualifier or sleep suspends without deselecting
   assign step = clk_en && !clock_qualify_n && !st_q.asleep;
   assign sel  = !cmd.chip_select_first_n
              && cmd.chip_select_second_high
              && !cmd.chip_select_third_n;

   // Asynchronous array read, registered below as output data
   assign rd_a = mem_a[st_q.st1_addr];
   assign rd_b = mem_b[st_q.st1_addr];

   pspc_burst u_burst (
      .clk        (clk),
      .rstn       (rstn),
      .clk_en     (clk_en),
      .step       (step),
      .load       (!cmd.adv_load),
      .base_in    (cmd.address[1:0]),
      .interleave (st_q.interleave),
      .lo_next    (lo_next)
   );

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      st_d = st_q;
      // Async pins pass two flops before use
      st_d.oe_s1 = output_enable_n;
      st_d.oe_s2 = st_q.oe_s1;
      st_d.zz_s1 = sleep_request;
      st_d.zz_s2 = st_q.zz_s1;
      st_d.md_s1 = burst_mode_strap;
      st_d.md_s2 = st_q.md_s1;
      st_d.asleep = st_q.zz_s2;
      // Strap caught once, after the synchroniser has filled
      if (st_q.strap_cnt != STRAP_DONE) begin
         st_d.strap_cnt = 2'(st_q.strap_cnt + 2'h1);
      end
      if (st_q.strap_cnt == STRAP_CAP) begin
         st_d.interleave = st_q.md_s2;
      end
      // Pipeline moves only on a qualified edge
      if (step) begin
         st_d.st2_op   = st_q.st1_op;
         st_d.st2_addr = st_q.st1_addr;
         st_d.st2_bw   = st_q.st1_bw;
         st_d.st1_bw   = cmd.byte_write_select_n;
         if (!cmd.adv_load) begin
            if (!sel) begin
               st_d.st1_op = PSPC_OP_IDLE;
            end else if (cmd.write_enable_n) begin
               st_d.st1_op = PSPC_OP_READ;
            end else begin
               st_d.st1_op = PSPC_OP_WRITE;
            end
            st_d.st1_addr = cmd.address;
         end else begin
            // Advance keeps the latched access type
            st_d.st1_addr = {st_q.st1_addr[ADDR_W-1:2], lo_next};
         end
         if (st_q.st1_op == PSPC_OP_READ) begin
            st_d.dq_out  = {rd_b[BYTE_W-1:0], rd_a[BYTE_W-1:0]};
            st_d.par_out = {rd_b[BYTE_W], rd_a[BYTE_W]};
         end
      end
      // Drive only for read data with enable low and awake; the
      // enable comes from the second sync flop, never the first
      st_d.oe = (st_d.st2_op == PSPC_OP_READ)
             && !st_q.oe_s2
             && !st_d.asleep;
      if (!rstn) begin
         st_d        = '0;
         st_d.oe_s1  = OE_N_RST;
         st_d.oe_s2  = OE_N_RST;
         st_d.zz_s1  = SLEEP_RST;
         st_d.zz_s2  = SLEEP_RST;
         st_d.st1_op = PSPC_OP_IDLE;
         st_d.st2_op = PSPC_OP_IDLE;
      end
   end

   // Clock enable low freezes everything; reset still acts
   always_ff @(posedge clk) begin
      if (clk_en || !rstn) begin
         st_q <= st_d;
      end
   end

   // ***************************************************************
   // Write data capture, per lane with its parity bit
   // ***************************************************************
   // Array kept outside the state struct: too large to reset
   always_ff @(posedge clk) begin
      if (rstn && step && st_q.st2_op == PSPC_OP_WRITE) begin
         if (!st_q.st2_bw[0]) begin
            mem_a[st_q.st2_addr] <= {parity_lines_in[0],
                                     dq_in[BYTE_W-1:0]};
         end
         if (!st_q.st2_bw[1]) begin
            mem_b[st_q.st2_addr] <= {parity_lines_in[1],
                                     dq_in[DATA_W-1:BYTE_W]};
         end
      end
   end

   // Outputs straight from the state flops
   assign dq_out           = st_q.dq_out;
   assign dq_oe            = st_q.oe;
   assign parity_lines_out = st_q.par_out;
   assign parity_lines_oe  = st_q.oe;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_cs2_low_desel: assert property (
      step && !cmd.adv_load && !cmd.chip_select_second_high
      |=> st_q.st1_op == PSPC_OP_IDLE)
      else $error("second select low did not deselect");

   a_cs3_high_desel: assert property (
      step && !cmd.adv_load && cmd.chip_select_third_n
      |=> st_q.st1_op == PSPC_OP_IDLE)
      else $error("third select high did not deselect");

   a_sel_read_load: assert property (
      step && !cmd.adv_load && sel && cmd.write_enable_n
      |=> st_q.st1_op == PSPC_OP_READ)
      else $error("selected read not loaded");

   a_oe_pin_gate: assert property (
      clk_en && st_q.oe_s2 |=> !dq_oe)
      else $error("data driven while output enable high");

   a_oe_mask_ops: assert property (
      dq_oe |-> st_q.st2_op == PSPC_OP_READ && !st_q.asleep)
      else $error("data driven outside read data phase");

   a_desel_pipe: assert property (
      (step && !cmd.adv_load && !sel) ##1 step |=> !dq_oe)
      else $error("outputs not off after deselect pipeline");

   a_hold_frozen: assert property (
      clk_en && clock_qualify_n
      |=> $stable(st_q.st1_op) && $stable(st_q.st2_op)
          && $stable(st_q.st1_addr) && $stable(dq_out))
      else $error("state moved while qualifier high");

   a_read_data: assert property (
      step && st_q.st1_op == PSPC_OP_READ
      |=> dq_out == $past({rd_b[BYTE_W-1:0], rd_a[BYTE_W-1:0]}))
      else $error("read data not from addressed word");

   a_sleep_quiet: assert property (
      clk_en && st_q.zz_s2 |=> !dq_oe && !step)
      else $error("activity while asleep");

   c_read_drive: cover property (
      step && st_q.st1_op == PSPC_OP_READ ##1 dq_oe);
   c_write_data: cover property (
      step && st_q.st2_op == PSPC_OP_WRITE);
   c_stretch: cover property (
      st_q.st2_op == PSPC_OP_READ && clk_en && clock_qualify_n);
   c_sleep: cover property (st_q.asleep);

endmodule

// file: bench/pspc_host_model.sv
// Purpose: Memory controller model facing the SRAM pin control
// Assumes: step is the clock edge qualified by clock enable and qualifier only, without the device's sleep term
// Notes:   Released data lines toggle so stale values never match
`timescale 1ns/1ps
module pspc_host_model (
   input  wire logic                        clk,
   input  wire logic                        step,
   output pspc_pkg::pspc_cmd_s              cmd,
   output logic [pspc_pkg::DATA_W-1:0]      dq_in,
   output logic [pspc_pkg::LANES-1:0]       par_in
);
   import pspc_pkg::*;
   logic [18:0] cur_q, s1_q, s2_q;  // Write flag, parity, data

   // Start deselected with the data lines quiet
   initial begin
      cmd = '0;
      cmd.chip_select_first_n = 1'b1;
      cur_q = '0;
      s1_q = '0;
      s2_q = '0;
      {par_in, dq_in} = '0;
   end

   // Write data trails its command by two qualified edges
   always @(posedge clk) begin
      if (step) begin
         s1_q <= cur_q;
         s2_q <= s1_q;
      end
   end

   // Drive write data, else a pattern that changes every cycle
   always @(negedge clk) begin
      {par_in, dq_in} <= s2_q[18] ? s2_q[17:0] : ~{par_in, dq_in};
   end

   // Present one command just after a falling edge
   task automatic issue(input logic [2:0]  cs,
                        input logic        we_n,
                        input logic        adv,
                        input logic [1:0]  bw_n,
                        input logic [7:0]  addr,
                        input logic [17:0] wd);
      @(negedge clk);
      {cmd.chip_select_first_n, cmd.chip_select_second_high,
       cmd.chip_select_third_n} = cs;
      cmd.write_enable_n      = we_n;
      cmd.adv_load            = adv;
      cmd.byte_write_select_n = bw_n;
      cmd.address             = {10'h000, addr};
      cur_q                   = {~we_n, wd};
   endtask
endmodule

// file: bench/pspc_ctrl_tb.sv
// Purpose: Self-checking bench of the SRAM pin control
// Assumes: Controller model presents commands after falling edges
// Notes:   Burst cases reset the block once for each strap level
`timescale 1ns/1ps
module pspc_ctrl_tb;
   import pspc_pkg::*;
   logic              clk, rstn, clk_en, qual_n, oe_n, sleep, strap;
   logic              step, dq_oe, par_oe;
   pspc_cmd_s         cmd;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic [LANES-1:0]  par_in, par_out;
   logic [29:0]       rows [8];  // rd, we_n, bw_n, addr, data
   int                num_errors = 0;
   int                n_checks = 0;
   int                k, j, s;

   assign step = clk_en & ~qual_n;
   pspc_host_model ctl (.clk(clk), .step(step), .cmd(cmd),
                        .dq_in(dq_in), .par_in(par_in));
   pspc_ctrl dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .cmd(cmd),
      .clock_qualify_n(qual_n), .output_enable_n(oe_n),
      .sleep_request(sleep), .burst_mode_strap(strap), .dq_in(dq_in),
      .parity_lines_in(par_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .parity_lines_out(par_out), .parity_lines_oe(par_oe));

   // Free-running clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // One access then a deselect; output must drop after the next rise
   task automatic op(input logic [2:0] cs, input logic we_n,
                     input logic [1:0] bw, input logic [7:0] a,
                     input logic [17:0] d, input logic rd, input logic eoe);
      ctl.issue(cs, we_n, 1'b0, bw, a, d);
      ctl.issue(3'b110, 1'b1, 1'b0, 2'h3, 8'h00, 18'h0);
      @(negedge clk);
      chk(18'(dq_oe), 18'(eoe));
      chk(18'(par_oe), 18'(eoe));
      if (rd) chk({par_out, dq_out}, d);
      @(negedge clk);
      chk(18'(dq_oe), 18'h0);
   endtask

   // Hang guard, far beyond the fewer than two hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      print_verdict();
   end

   // ***************************************************************
   // Stimulus
   // ***************************************************************
   initial begin
      {rstn, clk_en, qual_n, oe_n, sleep, strap} = 6'b010000;
      rows = '{{4'b0000, 8'h05, 18'h3a5a5}, {4'b1111, 8'h05, 18'h3a5a5},
               {4'b0010, 8'h05, 18'h01234}, {4'b1111, 8'h05, 18'h2a534},
               {4'b0001, 8'h05, 18'h07700}, {4'b1111, 8'h05, 18'h07734},
               {4'b0000, 8'h06, 18'h15aa5}, {4'b1111, 8'h06, 18'h15aa5}};
      // Burst order per strap: write four beats, read each back
      for (s = 1; s >= 0; s--) begin
         strap = s[0];
         rstn = 1'b0;
         repeat (16) @(negedge clk);
         rstn = 1'b1;
         chk({par_out, dq_out}, 18'h0);
         chk(18'(dq_oe), 18'h0);
         repeat (4) @(negedge clk);
         for (k = 0; k < 4; k++)
            ctl.issue(3'b010, 1'b0, k != 0, 2'h0, 8'h21,
                      18'(12'hb00 + s * 4 + k));
         for (k = 0; k < 4; k++)
            op(3'b010, 1'b1, 2'h3, 8'(32 + (s ? 1 ^ k : (1 + k) % 4)),
               18'(12'hb00 + s * 4 + k), 1'b1, 1'b1);
      end
      // Ordinary writes and read-backs, byte lanes included
      foreach (rows[i])
         op(3'b010, rows[i][28], rows[i][27:26], rows[i][25:18],
            rows[i][17:0], rows[i][29], rows[i][29]);
      // Each single select off must leave the pins released
      foreach (rows[i]) if (i < 3)
         op(3'b010 ^ (3'b100 >> i), 1'b1, 2'h3, 8'h05, 18'h0, 1'b0,
            1'b0);
      // Output enable high keeps pins off though data loads
      oe_n = 1'b1;
      repeat (3) @(negedge clk);
      op(3'b010, 1'b1, 2'h3, 8'h05, 18'h07734, 1'b1, 1'b0);
      oe_n = 1'b0;
      repeat (3) @(negedge clk);
      // Stall by qualifier, then by clock enable: nothing may move
      for (k = 0; k < 2; k++) begin
         ctl.issue(3'b010, 1'b1, 1'b0, 2'h3, 8'h06, 18'h0);
         ctl.issue(3'b110, 1'b1, 1'b0, 2'h3, 8'h00, 18'h0);
         for (j = 0; j < 2; j++) begin
            {clk_en, qual_n} = k ? 2'b00 : 2'b11;
            repeat (3) @(negedge clk);
            chk(18'(dq_oe), 18'(j));
            {clk_en, qual_n} = 2'b10;
            @(negedge clk);
            if (j == 0) chk({par_out, dq_out}, 18'h15aa5);
         end
         chk(18'(dq_oe), 18'h0);
      end
      // Asleep the read is ignored; awake the contents survive
      sleep = 1'b1;
      repeat (4) @(negedge clk);
      op(3'b010, 1'b1, 2'h3, 8'h05, 18'h0, 1'b0, 1'b0);
      sleep = 1'b0;
      repeat (4) @(negedge clk);
      op(3'b010, 1'b1, 2'h3, 8'h05, 18'h07734, 1'b1, 1'b1);
      print_verdict();
   end
endmodule
